// ### inc/fcl_pkg.sv
// Package of constants for the embedded flash controller command logic
package fcl_pkg;
   // ------------------------------------------------------------------
   // Organisation
   // ------------------------------------------------------------------
   localparam int PAGE_BYTES      = 256;
   localparam int PAGES_SINGLE    = 2048;
   localparam int PAGES_PER_BANK  = 1024;
   localparam int PAGE_AW         = 11;
   localparam int LOCK_REGIONS    = 16;
   localparam int LOCK_PAGES      = 128;
   localparam int WBUF_BYTES      = 128;
   localparam int WBUF_WORDS      = WBUF_BYTES / 4;
   localparam int WBUF_AW         = 5;
   localparam int NVB_SINGLE      = 2;
   localparam int NVB_DUAL        = 3;
   // ------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [11:0] OFF_MODE   = 12'h000;
   localparam logic [11:0] OFF_CMD    = 12'h004;
   localparam logic [11:0] OFF_STAT   = 12'h008;
   localparam logic [11:0] OFF_RESULT = 12'h00c;
   localparam logic [11:0] OFF_LOCKS  = 12'h010;
   localparam logic [11:0] OFF_NVBITS = 12'h014;
   localparam logic [11:0] OFF_BOOT   = 12'h018;
   localparam logic [11:0] OFF_UID0   = 12'h020;
   localparam logic [11:0] OFF_CAL    = 12'h030;
   localparam logic [11:0] OFF_WBUF   = 12'h100;
   // ------------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------------
   localparam int MODE_WS_LSB   = 0;
   localparam int MODE_WS_W     = 4;
   localparam int MODE_WIDE_BIT = 8;
   localparam int CMD_KEY_LSB   = 24;
   localparam int CMD_ARG_LSB   = 8;
   localparam logic [7:0] CMD_KEY = 8'h5a;
   localparam int STAT_READY    = 0;
   localparam int STAT_CMDERR   = 1;
   localparam int STAT_LOCKERR  = 2;
   localparam int STAT_IRQ      = 3;
   localparam logic [3:0]  MODE_WS_RST  = 4'h0;
   localparam logic        MODE_WIDE_RST = 1'b1;
   localparam logic [31:0] CAL_VALUE    = 32'h0000_0000;  // Arbitrary factory value
   localparam logic [127:0] UID_VALUE   = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210; // Arbitrary
   localparam logic [31:0] DEV_ID       = 32'h0000_0001;  // Arbitrary identity value
   // ------------------------------------------------------------------
   // Timing: slow clock and erase pin debounce
   // ------------------------------------------------------------------
   localparam int CLK_HZ        = 50_000_000;
   localparam int SLOW_HZ       = 32_768;
   localparam int SLOW_DIV      = CLK_HZ / SLOW_HZ;
   localparam int ERASE_IGN_MS  = 100;
   localparam int ERASE_ACT_MS  = 220;
   localparam int ERASE_HOLD_MS = 200;
   localparam int ERASE_IGN_TK  = (ERASE_IGN_MS * SLOW_HZ) / 1000;
   localparam int ERASE_ACT_TK  = (ERASE_ACT_MS * SLOW_HZ + 999) / 1000;
   localparam int PROG_CYCLES   = 64;
   localparam int ERASE_CYCLES  = 128;
   // ------------------------------------------------------------------
   // Commands
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      FCL_GET_DESC  = 4'h0,
      FCL_WRITE_PG  = 4'h1,
      FCL_ERASE_PG  = 4'h2,
      FCL_ERASE_ALL = 4'h3,
      FCL_SET_LOCK  = 4'h4,
      FCL_CLR_LOCK  = 4'h5,
      FCL_SET_NVB   = 4'h6,
      FCL_CLR_NVB   = 4'h7
   } fcl_cmd_t;
endpackage : fcl_pkg

// ### design/fcl_wbuf.sv
// Write buffer memory with registered read data
`timescale 1ns/1ps
module fcl_wbuf #(
   parameter int DW = 32,
   parameter int AW = 5
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : fcl_wbuf

// ### design/fcl_ctrl.sv
// Flash controller: APB user interface, command sequencer, locks and NV bits
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module fcl_ctrl
   import fcl_pkg::*;
#(
   parameter bit DUAL_BANK     = 1'b0,
   parameter int SLOW_DIVIDE   = SLOW_DIV,
   parameter int ERASE_IGN     = ERASE_IGN_TK,
   parameter int ERASE_ACT     = ERASE_ACT_TK
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        erase_pin,
   input  wire logic        read_req,
   input  wire logic        read_bank,
   output logic             read_grant,
   output logic             busy,
   output logic             irq,
   output logic             secure,
   output logic             boot_flash,
   output logic             boot_bank1,
   output logic             rom_at_zero,
   output logic             wide_read,
   output logic [3:0]       wait_states,
   output logic             prog_we,
   output logic             prog_bank,
   output logic [PAGE_AW-1:0] prog_page,
   output logic [4:0]       prog_word,
   output logic [31:0]      prog_data,
   output logic             erase_en,
   output logic             erase_all
);
   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (SLOW_DIVIDE < 1 || SLOW_DIVIDE > 65536 || ERASE_IGN < 1 ||
       ERASE_ACT <= ERASE_IGN || ERASE_ACT > 65535) begin : g_chk
      $error("fcl_ctrl: bad debounce parameters");
   end

   localparam int NVB = DUAL_BANK ? NVB_DUAL : NVB_SINGLE;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_PROG  = 3'b001,
      ST_ERASE = 3'b010,
      ST_DONE  = 3'b011
   } fcl_state_t;

   // Lock region of a page number, independent of bank split
   function automatic logic [3:0] lock_region(input logic [PAGE_AW-1:0] pg);
      lock_region = pg[PAGE_AW-1 -: 4];
   endfunction : lock_region

   // Word-aligned register address decode
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a[11:2] == off[11:2]);
   endfunction : hit

   fcl_state_t           state_q;
   logic [3:0]           ws_q;
   logic                 wide_q;
   logic [15:0]          locks_q;
   logic [2:0]           nvb_q;
   logic                 cmderr_q;
   logic                 lockerr_q;
   logic                 done_q;
   logic [31:0]          result_q;
   logic [PAGE_AW-1:0]   page_q;
   logic                 is_all_q;
   logic [7:0]           cnt_q;
   logic [4:0]           pw_q;
   logic                 erase_arm_q;
   logic [15:0]          div_q;
   logic                 slow_tick;
   logic [15:0]          deb_q;
   logic                 erase_evt;
   logic                 pin_full_erase;

   wire wr_en = psel & penable & pwrite;
   wire rd_en = psel & penable & ~pwrite;
   wire cmd_wr = wr_en & hit(paddr, OFF_CMD) & (pwdata[31:CMD_KEY_LSB] == CMD_KEY);
   wire [3:0] cmd_op = pwdata[3:0];
   wire [PAGE_AW-1:0] cmd_arg = pwdata[CMD_ARG_LSB +: PAGE_AW];
   wire wbuf_wr = wr_en & (paddr[11:7] == OFF_WBUF[11:7]) & (state_q == ST_IDLE);

   // ------------------------------------------------------------------
   // APB slave: zero wait states, unmapped access errors
   // ------------------------------------------------------------------
   logic mapped;
   always_comb begin
      mapped = hit(paddr, OFF_MODE) | hit(paddr, OFF_CMD) | hit(paddr, OFF_STAT) |
               hit(paddr, OFF_RESULT) | hit(paddr, OFF_LOCKS) | hit(paddr, OFF_NVBITS) |
               hit(paddr, OFF_BOOT) | (paddr[11:4] == OFF_UID0[11:4]) |
               hit(paddr, OFF_CAL) | (paddr[11:7] == OFF_WBUF[11:7]);
   end
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= 32'h0000_0000;
         if (hit(paddr, OFF_MODE))   prdata <= {23'h0, wide_q, 4'h0, ws_q};
         if (hit(paddr, OFF_STAT))   prdata <= {28'h0, irq, lockerr_q, cmderr_q, ~busy};
         if (hit(paddr, OFF_RESULT)) prdata <= result_q;
         if (hit(paddr, OFF_LOCKS))  prdata <= {16'h0, locks_q};
         if (hit(paddr, OFF_NVBITS)) prdata <= {29'h0, nvb_q};
         if (hit(paddr, OFF_BOOT))   prdata <= {29'h0, rom_at_zero, boot_bank1, boot_flash};
         if (paddr[11:4] == OFF_UID0[11:4])
            prdata <= UID_VALUE[32*paddr[3:2] +: 32];
         if (hit(paddr, OFF_CAL))    prdata <= CAL_VALUE;
      end
   end

   // ------------------------------------------------------------------
   // Mode register: wait states and read width
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ws_q   <= MODE_WS_RST;
         wide_q <= MODE_WIDE_RST;
      end else if (wr_en && hit(paddr, OFF_MODE)) begin
         ws_q   <= pwdata[MODE_WS_LSB +: MODE_WS_W];
         wide_q <= pwdata[MODE_WIDE_BIT];
      end
   end
   assign wide_read   = wide_q;
   assign wait_states = ws_q;

   // ------------------------------------------------------------------
   // Slow clock enable and erase pin debounce
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 16'h0000;
      end else if (div_q == 16'(SLOW_DIVIDE - 1)) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end
   assign slow_tick = (div_q == 16'(SLOW_DIVIDE - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deb_q <= 16'h0000;
      end else if (!erase_pin) begin
         deb_q <= 16'h0000;
      end else if (slow_tick && deb_q != 16'(ERASE_ACT)) begin
         deb_q <= deb_q + 16'h0001;
      end
   end
   // Fires once when the pin has been high past the action threshold
   assign erase_evt = slow_tick & erase_pin & (deb_q == 16'(ERASE_ACT - 1));

   // ------------------------------------------------------------------
   // Lock bits
   // ------------------------------------------------------------------
   wire lock_hit = locks_q[lock_region(cmd_arg)];
   wire cmd_ok   = cmd_wr & (state_q == ST_IDLE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         locks_q <= 16'h0000;
      end else if (erase_evt) begin
         locks_q <= 16'h0000;
      end else if (cmd_ok && cmd_op == FCL_SET_LOCK) begin
         locks_q[lock_region(cmd_arg)] <= 1'b1;
      end else if (cmd_ok && cmd_op == FCL_CLR_LOCK) begin
         locks_q[lock_region(cmd_arg)] <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // General non-volatile configuration bits
   // ------------------------------------------------------------------
   wire [1:0] nv_idx = pwdata[CMD_ARG_LSB +: 2];
   wire       nv_ok  = 32'(nv_idx) < NVB;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nvb_q <= 3'b000;
      end else if (erase_evt) begin
         nvb_q[2:1] <= 2'b00;
      end else if (pin_full_erase) begin
         nvb_q[0] <= 1'b0;
      end else if (cmd_ok && nv_ok && cmd_op == FCL_SET_NVB) begin
         nvb_q[nv_idx] <= 1'b1;
      end else if (cmd_ok && nv_ok && cmd_op == FCL_CLR_NVB && nv_idx != 2'd0) begin
         nvb_q[nv_idx] <= 1'b0;
      end
   end
   assign secure      = nvb_q[0];
   assign boot_flash  = nvb_q[1];
   assign boot_bank1  = DUAL_BANK & nvb_q[2];
   assign rom_at_zero = ~nvb_q[1];

   // ------------------------------------------------------------------
   // Command sequencer
   // ------------------------------------------------------------------
   wire needs_lock = (cmd_op == FCL_WRITE_PG) | (cmd_op == FCL_ERASE_PG);
   wire [PAGE_AW-1:0] max_pg = PAGE_AW'(PAGES_SINGLE - 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q  <= ST_IDLE;
         page_q   <= '0;
         is_all_q <= 1'b0;
         cnt_q    <= 8'h00;
         pw_q     <= 5'h00;
         result_q <= 32'h0000_0000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (erase_evt) begin
                  is_all_q <= 1'b1;
                  cnt_q    <= 8'(ERASE_CYCLES - 1);
                  state_q  <= ST_ERASE;
               end else if (cmd_ok && !(needs_lock && lock_hit) && cmd_arg <= max_pg) begin
                  page_q <= cmd_arg;
                  pw_q   <= 5'h00;
                  case (cmd_op)
                     FCL_WRITE_PG: begin
                        cnt_q   <= 8'(WBUF_WORDS - 1);
                        state_q <= ST_PROG;
                     end
                     FCL_ERASE_PG, FCL_ERASE_ALL: begin
                        is_all_q <= (cmd_op == FCL_ERASE_ALL);
                        cnt_q    <= 8'(ERASE_CYCLES - 1);
                        state_q  <= ST_ERASE;
                     end
                     FCL_GET_DESC: begin
                        result_q <= {DEV_ID[7:0], 4'(LOCK_REGIONS - 1), DUAL_BANK,
                                     3'(NVB), 16'(PAGES_SINGLE)};
                     end
                     default: begin
                     end
                  endcase
               end
            end
            ST_PROG: begin
               pw_q <= pw_q + 5'h01;
               if (cnt_q == 8'h00) state_q <= ST_DONE;
               else cnt_q <= cnt_q - 8'h01;
            end
            ST_ERASE: begin
               if (cnt_q == 8'h00) state_q <= ST_DONE;
               else cnt_q <= cnt_q - 8'h01;
            end
            ST_DONE: begin
               is_all_q <= 1'b0;
               state_q  <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Security clears when a full erase finishes after an erase pin event, whether the pin started it or it was already running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erase_arm_q <= 1'b0;
      end else if (erase_evt) begin
         erase_arm_q <= 1'b1;
      end else if (state_q == ST_DONE) begin
         erase_arm_q <= 1'b0;
      end
   end
   assign pin_full_erase = erase_arm_q & is_all_q & (state_q == ST_DONE);

   assign busy = (state_q != ST_IDLE);

   // ------------------------------------------------------------------
   // Status flags: set wins over clear-on-read
   // ------------------------------------------------------------------
   wire stat_rd = rd_en & hit(paddr, OFF_STAT);
   wire lock_viol = cmd_ok & needs_lock & lock_hit;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lockerr_q <= 1'b0;
         cmderr_q  <= 1'b0;
         done_q    <= 1'b0;
      end else begin
         lockerr_q <= lock_viol | (lockerr_q & ~stat_rd);
         cmderr_q  <= (cmd_wr & busy) | (cmd_ok & cmd_arg > max_pg) |
                      (cmderr_q & ~stat_rd);
         done_q    <= (state_q == ST_DONE) | (done_q & ~stat_rd);
      end
   end
   assign irq = lockerr_q | done_q;

   // ------------------------------------------------------------------
   // Array programming path and bank arbitration
   // ------------------------------------------------------------------
   logic [31:0] wb_rdata;
   fcl_wbuf #(.DW(32), .AW(WBUF_AW)) u_wbuf (
      .clk   (pclk),
      .we    (wbuf_wr),
      .waddr (paddr[WBUF_AW+1:2]),
      .wdata (pwdata),
      .raddr (pw_q),
      .rdata (wb_rdata)
   );

   logic prog_we_q;
   logic [4:0] prog_word_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_we_q   <= 1'b0;
         prog_word_q <= 5'h00;
      end else begin
         prog_we_q   <= (state_q == ST_PROG);
         prog_word_q <= pw_q;
      end
   end
   assign prog_we   = prog_we_q;
   assign prog_word = prog_word_q;
   assign prog_data = wb_rdata;
   assign prog_page = page_q;
   assign prog_bank = DUAL_BANK & page_q[PAGE_AW-1];
   assign erase_en  = (state_q == ST_ERASE);
   assign erase_all = is_all_q;

   // Reads are granted only to the bank not being programmed or erased
   assign read_grant = read_req & (~busy | (DUAL_BANK & ~is_all_q &
                       (read_bank != prog_bank)));
endmodule : fcl_ctrl

// ### bench/fcl_ctrl_checker.sv
// Checker of the flash controller port relations
`timescale 1ns/1ps
module fcl_ctrl_checker #(
   parameter bit DUAL_BANK = 1'b0
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       erase_pin,
   input wire logic       read_req,
   input wire logic       read_grant,
   input wire logic       busy,
   input wire logic       secure,
   input wire logic       boot_flash,
   input wire logic       boot_bank1,
   input wire logic       rom_at_zero,
   input wire logic       wide_read,
   input wire logic [3:0] wait_states,
   input wire logic       prog_we
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Remembers that the erase pin was seen high since reset
   logic pin_seen_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pin_seen_q <= 1'b0;
      else if (erase_pin) pin_seen_q <= 1'b1;
   end
   zero_wait_a: assert property (pready) else $error("pready low");
   err_access_a: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   rom_map_a: assert property (rom_at_zero == !boot_flash)
      else $error("rom mapping wrong");
   bank_sel_a: assert property (!DUAL_BANK |-> !boot_bank1)
      else $error("bank bit in single bank");
   sec_clear_a: assert property ($fell(secure) |-> pin_seen_q)
      else $error("security cleared without erase pin");
   mode_reset_a: assert property ($rose(presetn) |-> wide_read && wait_states == 4'h0)
      else $error("mode reset value wrong");
   grant_req_a: assert property (read_grant |-> read_req)
      else $error("grant without request");
   prog_busy_a: assert property (prog_we |-> busy)
      else $error("program word while idle");
endmodule : fcl_ctrl_checker
bind fcl_ctrl fcl_ctrl_checker #(.DUAL_BANK(DUAL_BANK)) u_fcl_ctrl_checker (
   .pclk, .presetn, .psel, .penable, .pready, .pslverr, .erase_pin, .read_req,
   .read_grant, .busy, .secure, .boot_flash, .boot_bank1, .rom_at_zero,
   .wide_read, .wait_states, .prog_we);

// ### bench/fcl_rd_master.sv
// Model of a system bus master that asks for array reads
`timescale 1ns/1ps
module fcl_rd_master (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic go,
   input  wire logic bank,
   input  wire logic read_grant,
   output logic      read_req,
   output logic      read_bank,
   output logic      got
);
   // Request and bank held until the grant; bank line scrambled after
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_req  <= 1'b0;
         read_bank <= 1'b0;
         got       <= 1'b0;
      end else if (read_req && read_grant) begin
         read_req  <= 1'b0;
         read_bank <= ~read_bank;
         got       <= 1'b1;
      end else if (go && !read_req) begin
         read_req  <= 1'b1;
         read_bank <= bank;
         got       <= 1'b0;
      end
   end
endmodule : fcl_rd_master

// ### bench/fcl_ctrl_tb.sv
// Self-checking bench of the flash controller command logic
`timescale 1ns/1ps
module fcl_ctrl_tb
   import fcl_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, erase_pin, go, bank, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        pready, pslverr, read_req, read_bank, read_grant, busy, irq, secure;
   logic        boot_flash, boot_bank1, rom_at_zero, wide_read, prog_we, got;
   logic [3:0]  wait_states;
   int          error_cnt, tests_run, wcnt, w0;
   fcl_ctrl #(.SLOW_DIVIDE(2), .ERASE_IGN(2), .ERASE_ACT(4)) u_fcl_ctrl (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .erase_pin, .read_req, .read_bank, .read_grant, .busy, .irq, .secure,
      .boot_flash, .boot_bank1, .rom_at_zero, .wide_read, .wait_states, .prog_we,
      .prog_bank(), .prog_page(), .prog_word(), .prog_data(), .erase_en(), .erase_all());
   fcl_rd_master u_fcl_rd_master (
      .pclk, .presetn, .go, .bank, .read_grant, .read_req, .read_bank, .got);
   initial pclk = 1'b0;
   always #10 pclk = ~pclk;
   always @(posedge pclk) if (prog_we === 1'b1) wcnt <= wcnt + 1;
   // ------------------------------------------------------------------
   // Bus and check helpers
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic idle();
      repeat (2) @(posedge pclk);
      repeat (400) if (busy === 1'b1) @(posedge pclk);
   endtask : idle
   function automatic logic [31:0] cw(input logic [3:0] op, input logic [10:0] pg);
      return {CMD_KEY, 5'h00, pg, 4'h0, op};
   endfunction : cw
   task automatic cmd(input logic [3:0] op, input logic [10:0] pg);
      apb(1'b1, OFF_CMD, cw(op, pg));
      idle();
   endtask : cmd
   task automatic t_regs();
      apb(1'b0, OFF_MODE, 32'h0);
      chk(q, 32'h0000_0100);
      apb(1'b1, OFF_MODE, 32'h0000_0003);
      apb(1'b0, OFF_MODE, 32'h0);
      chk({q[8], wide_read, q[3:0], wait_states}, 32'h33);
      apb(1'b1, OFF_CAL, 32'hffff_ffff);
      apb(1'b0, OFF_CAL, 32'h0);
      chk(q, CAL_VALUE);
      apb(1'b0, 12'h200, 32'h0);
      chk({31'h0, err}, 32'h1);
      cmd(FCL_GET_DESC, 11'h000);
      apb(1'b0, OFF_RESULT, 32'h0);
      chk(q, {DEV_ID[7:0], 4'hf, 1'h0, 3'h2, 16'h0800});
      $display("test regs done");
   endtask : t_regs
   task automatic t_lock();
      for (int i = 0; i < WBUF_WORDS; i++) apb(1'b1, OFF_WBUF + 12'(4 * i), 32'(i));
      cmd(FCL_SET_LOCK, 11'h080);
      apb(1'b0, OFF_LOCKS, 32'h0);
      chk(q, 32'h2);
      apb(1'b0, OFF_STAT, 32'h0);
      w0 = wcnt;
      cmd(FCL_WRITE_PG, 11'h080);
      chk({31'h0, irq}, 32'h1);
      chk(32'(wcnt - w0), 32'h0);
      apb(1'b0, OFF_STAT, 32'h0);
      chk({31'h0, q[STAT_LOCKERR]}, 32'h1);
      apb(1'b0, OFF_STAT, 32'h0);
      chk({31'h0, q[STAT_LOCKERR]}, 32'h0);
      cmd(FCL_CLR_LOCK, 11'h080);
      w0 = wcnt;
      apb(1'b1, OFF_CMD, cw(FCL_WRITE_PG, 11'h080));
      apb(1'b1, OFF_CMD, cw(FCL_ERASE_PG, 11'h000));
      idle();
      chk(32'(wcnt - w0), 32'(WBUF_WORDS));
      apb(1'b0, OFF_STAT, 32'h0);
      chk({30'h0, q[STAT_CMDERR], q[STAT_READY]}, 32'h3);
      $display("test lock done");
   endtask : t_lock
   task automatic t_nvb();
      cmd(FCL_SET_NVB, 11'h001);
      chk({30'h0, boot_flash, rom_at_zero}, 32'h2);
      cmd(FCL_CLR_NVB, 11'h001);
      chk({30'h0, boot_flash, rom_at_zero}, 32'h1);
      cmd(FCL_SET_NVB, 11'h002);
      chk({31'h0, boot_bank1}, 32'h0);
      cmd(FCL_SET_NVB, 11'h000);
      cmd(FCL_CLR_NVB, 11'h000);
      chk({31'h0, secure}, 32'h1);
      $display("test nvb done");
   endtask : t_nvb
   task automatic t_erase();
      cmd(FCL_SET_LOCK, 11'h000);
      cmd(FCL_SET_NVB, 11'h001);
      erase_pin <= 1'b1;
      repeat (2) @(posedge pclk);
      erase_pin <= 1'b0;
      repeat (20) @(posedge pclk);
      apb(1'b0, OFF_LOCKS, 32'h0);
      chk(q, 32'h1);
      erase_pin <= 1'b1;
      repeat (40) @(posedge pclk);
      erase_pin <= 1'b0;
      idle();
      apb(1'b0, OFF_LOCKS, 32'h0);
      chk(q, 32'h0);
      chk({30'h0, boot_flash, secure}, 32'h0);
      apb(1'b0, OFF_UID0, 32'h0);
      chk(q, UID_VALUE[31:0]);
      $display("test erase done");
   endtask : t_erase
   task automatic t_read();
      apb(1'b1, OFF_CMD, cw(FCL_ERASE_ALL, 11'h000));
      go   <= 1'b1;
      bank <= 1'b0;
      @(posedge pclk);
      go <= 1'b0;
      repeat (20) @(posedge pclk);
      chk({30'h0, busy, got}, 32'h2);
      idle();
      repeat (2) @(posedge pclk);
      chk({31'h0, got}, 32'h1);
      $display("test read done");
   endtask : t_read
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop
   initial begin
      {psel, penable, pwrite, erase_pin, go, bank, presetn} = 7'h00;
      paddr  = 12'h000;
      pwdata = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_lock();
      t_nvb();
      t_erase();
      t_read();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule : fcl_ctrl_tb
